// *** verilog/temp_regs_pkg.sv ***
package temp_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] ADDR_REMOTE_HI = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h05;
  localparam logic [7:0] ADDR_RHIGH_HI = 8'h07;
  localparam logic [7:0] ADDR_RLOW_HI = 8'h08;
  localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
  localparam logic [7:0] ADDR_OFS_HI = 8'h11;
  localparam logic [7:0] ADDR_OFS_LO = 8'h12;
  localparam logic [7:0] ADDR_RHIGH_LO = 8'h13;
  localparam logic [7:0] ADDR_RLOW_LO = 8'h14;
  localparam logic [7:0] ADDR_CRIT = 8'h19;
  localparam logic [7:0] ADDR_HYST = 8'h21;
  localparam logic [7:0] ADDR_FILTER = 8'hbf;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LOCAL_HIGH = 8'h46;
  localparam logic [7:0] RST_RHIGH_HI = 8'h46;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CRIT = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0a;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [10:0] RST_READING = 11'h000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_LOCAL_HIGH = 6;
  localparam int STAT_REMOTE_HIGH = 4;
  localparam int STAT_REMOTE_LOW = 3;
  localparam int CTRL_COMPARATOR = 0;
  localparam int CTRL_FILTER_LSB = 1;
  localparam int COND_LOCAL_HIGH = 0;
  localparam int COND_REMOTE_HIGH = 1;
  localparam int COND_REMOTE_LOW = 2;
  localparam int FILTER_FRAC = 3;

  typedef enum logic [1:0] {FILT_OFF, FILT_MIN, FILT_MAX} filter_mode_t;

  // Joins a high byte and the three fraction bits of a low byte.
  function automatic logic [10:0] fmt11(input logic [7:0] hi, input logic [7:0] lo);
    fmt11 = {hi, lo[7:5]};
  endfunction

  // Places three fraction bits at the top of a low byte.
  function automatic logic [7:0] frac_byte(input logic [2:0] f);
    frac_byte = {f, 5'h00};
  endfunction

  // Maps the two filter select bits onto a filter strength.
  function automatic filter_mode_t filter_mode(input logic [1:0] sel);
    case (sel)
      2'h0: filter_mode = FILT_OFF;
      2'h3: filter_mode = FILT_MAX;
      default: filter_mode = FILT_MIN;
    endcase
  endfunction

endpackage

// *** verilog/alarm_if.sv ***
interface alarm_if;
  logic [2:0] cond;
  logic clear_rd;
  logic [2:0] latched;
  modport core (output cond, output clear_rd, input latched);
  modport latch (input cond, input clear_rd, output latched);
endinterface

// *** verilog/remote_filter.sv ***
module remote_filter
  import temp_regs_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic in_valid, // New converter sample.
  input wire logic [10:0] in_data, // Signed sample, eighths of a degree.
  input wire logic [1:0] sel, // Filter select bits.
  output logic out_valid, // Filtered value updated.
  output logic [10:0] out_data // Filtered signed value.
);

  logic [13:0] acc;
  logic primed;
  logic [13:0] sample_ext;
  logic [13:0] step;
  filter_mode_t mode;

  // ----------------------------------------------------------------
  // First order smoothing
  // ----------------------------------------------------------------
  // Extra fraction bits keep small steps from being lost to truncation.
  always_comb begin
    mode = filter_mode(sel);
    sample_ext = {in_data, 3'h0};
    case (mode)
      FILT_MIN: step = 14'($signed(sample_ext - acc) >>> 1);
      FILT_MAX: step = 14'($signed(sample_ext - acc) >>> 2);
      default: step = 14'(sample_ext - acc);
    endcase
  end

  // The first sample loads directly so that start-up does not ramp from zero.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc <= 14'h0000;
      primed <= 1'b0;
    end else if (in_valid) begin
      primed <= 1'b1;
      acc <= primed ? 14'(acc + step) : sample_ext;
    end
  end

  // Marks each new filtered value.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
    end
  end

  assign out_data = acc[13:FILTER_FRAC];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  filter_bypass_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (in_valid && sel == 2'h0) |=> (out_data == $past(in_data) && out_valid))
    else $error("Unfiltered mode did not pass the sample through.");

endmodule

// *** verilog/alarm_latch.sv ***
module alarm_latch
  import temp_regs_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  alarm_if.latch al // Conditions in, latched alarms out.
);

  // ----------------------------------------------------------------
  // Sticky alarms
  // ----------------------------------------------------------------
  // A live condition always wins over a status read, so no event is lost.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      al.latched <= 3'h0;
    end else begin
      al.latched <= al.cond | (al.latched & ~{3{al.clear_rd}});
    end
  end

  sticky_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (!al.clear_rd && al.latched != 3'h0)
    |=> ((al.latched & $past(al.latched)) == $past(al.latched)))
    else $error("Latched alarm dropped without a status read.");

  read_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (al.clear_rd && al.cond == 3'h0) |=> (al.latched == 3'h0) [*1])
    else $error("Status read did not clear a gone alarm.");

endmodule

// *** verilog/temp_result_regs.sv ***
// Summary of operation
// - Local die reading is a read-only 8-bit integer.
// - Remote high byte is two's complement, bit 0 weighs one degree.
// - Remote low byte holds three fraction bits; bits 4 to 0 read zero.
// - Signed offset is added to the filtered converter output to form the result.
// - Local high setpoint is read-write and resets to 0x46.
// - Remote high setpoint uses reading format, resets to 0x46 and zero.
// - Remote low setpoint uses reading format and resets to zero.
// - Critical limit is an 8-bit integer resetting to 0x55.
// - Critical limit is written only while the unlock bit is one.
// - After one unlocked write the critical limit is frozen until reset.
// - Critical flag holds until remote falls below limit minus hysteresis.
// - Filter select: 00 off, 01 or 10 minimal, 11 maximum; resets to 00.
// - Comparator bit set makes alert follow live conditions.
// - Alarm bits latch until read, then clear only if condition is gone.
// - Local above local high setpoint sets status bit 6 and alerts.
// - Remote above remote high setpoint sets status bit 4 and alerts.
// - Remote below remote low setpoint sets status bit 3 and alerts.
module temp_result_regs
  import temp_regs_pkg::*;
(
  input wire logic sys_clk, // System clock, 25 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic sample_valid, // One-cycle pulse with new converter outputs.
  input wire logic [7:0] local_adc, // Local die converter output.
  input wire logic [10:0] remote_adc, // Remote converter output, signed eighths.
  input wire logic critical_limit_unlock, // Configuration unlock bit level.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic reg_wr, // One-cycle write strobe.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_rd, // One-cycle read strobe.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  output logic critical_temp_flag, // Critical temperature level.
  output logic alert_n_out, // Alert pin level when driven.
  output logic alert_n_oe // Alert pin enable, high while pulling low.
);

  logic [7:0] local_temp;
  logic [10:0] remote_result;
  logic [2:0] lo_shadow;
  logic lo_frozen;
  logic [7:0] local_high;
  logic [7:0] rhigh_hi;
  logic [7:0] rhigh_lo;
  logic [7:0] rlow_hi;
  logic [7:0] rlow_lo;
  logic [7:0] ofs_hi;
  logic [7:0] ofs_lo;
  logic [7:0] critical_limit;
  logic [7:0] critical_hyst;
  logic crit_used;
  logic [2:0] ctrl;
  logic filt_valid;
  logic [10:0] filt_data;
  logic [9:0] remote_int;
  logic [9:0] crit_ext;
  logic [9:0] crit_release;
  logic [7:0] status_byte;
  logic [7:0] next_rdata;
  logic wr_crit_ok;

  alarm_if al_bus();

  // ----------------------------------------------------------------
  // Remote filter and alarm latch
  // ----------------------------------------------------------------
  remote_filter u_filter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(sample_valid),
    .in_data(remote_adc),
    .sel(ctrl[CTRL_FILTER_LSB +: 2]),
    .out_valid(filt_valid),
    .out_data(filt_data)
  );

  alarm_latch u_latch (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .al(al_bus.latch)
  );

  // ----------------------------------------------------------------
  // Readings
  // ----------------------------------------------------------------
  // Local reading is stored as delivered; software cannot write it.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      local_temp <= RST_ZERO;
    end else if (sample_valid) begin
      local_temp <= local_adc;
    end
  end

  // The offset joins the result after filtering; wrap-around is not saturated.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      remote_result <= RST_READING;
    end else if (filt_valid) begin
      remote_result <= 11'(filt_data + fmt11(ofs_hi, ofs_lo));
    end
  end

  // A high byte read snapshots the fraction bits, so a conversion landing
  // between the two reads cannot tear the sample.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lo_shadow <= 3'h0;
      lo_frozen <= 1'b0;
    end else if (reg_rd && reg_addr == ADDR_REMOTE_HI) begin
      lo_shadow <= remote_result[2:0];
      lo_frozen <= 1'b1;
    end else if (reg_rd && reg_addr == ADDR_REMOTE_LO) begin
      lo_frozen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Setpoints and control
  // ----------------------------------------------------------------
  // Low bytes keep only the three fraction bits; the rest read as zero.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      local_high <= RST_LOCAL_HIGH;
      rhigh_hi <= RST_RHIGH_HI;
      rhigh_lo <= RST_ZERO;
      rlow_hi <= RST_ZERO;
      rlow_lo <= RST_ZERO;
      ofs_hi <= RST_ZERO;
      ofs_lo <= RST_ZERO;
      critical_hyst <= RST_HYST;
      ctrl <= RST_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_LOCAL_HIGH: local_high <= reg_wdata;
        ADDR_RHIGH_HI: rhigh_hi <= reg_wdata;
        ADDR_RHIGH_LO: rhigh_lo <= frac_byte(reg_wdata[7:5]);
        ADDR_RLOW_HI: rlow_hi <= reg_wdata;
        ADDR_RLOW_LO: rlow_lo <= frac_byte(reg_wdata[7:5]);
        ADDR_OFS_HI: ofs_hi <= reg_wdata;
        ADDR_OFS_LO: ofs_lo <= frac_byte(reg_wdata[7:5]);
        ADDR_HYST: critical_hyst <= reg_wdata;
        ADDR_FILTER: ctrl <= reg_wdata[2:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  assign wr_crit_ok = reg_wr && reg_addr == ADDR_CRIT && critical_limit_unlock && !crit_used;

  // Only the first unlocked write lands; reset alone re-arms it.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      critical_limit <= RST_CRIT;
      crit_used <= 1'b0;
    end else if (wr_crit_ok) begin
      critical_limit <= reg_wdata;
      crit_used <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Critical flag with hysteresis
  // ----------------------------------------------------------------
  // Ten signed bits hold the whole-degree reading and limit minus hysteresis.
  always_comb begin
    remote_int = {{2{remote_result[10]}}, remote_result[10:3]};
    crit_ext = {2'h0, critical_limit};
    crit_release = 10'(crit_ext - {2'h0, critical_hyst});
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      critical_temp_flag <= 1'b0;
    end else if ($signed(remote_int) > $signed(crit_ext)) begin
      critical_temp_flag <= 1'b1;
    end else if ($signed(remote_int) < $signed(crit_release)) begin
      critical_temp_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Alarm conditions and alert pin
  // ----------------------------------------------------------------
  always_comb begin
    al_bus.cond[COND_LOCAL_HIGH] = $signed(local_temp) > $signed(local_high);
    al_bus.cond[COND_REMOTE_HIGH] =
      $signed(remote_result) > $signed(fmt11(rhigh_hi, rhigh_lo));
    al_bus.cond[COND_REMOTE_LOW] =
      $signed(remote_result) < $signed(fmt11(rlow_hi, rlow_lo));
    al_bus.clear_rd = reg_rd && reg_addr == ADDR_STATUS;
  end

  // Normal mode follows the latched alarms; comparator mode follows the
  // live conditions so the pin drops as soon as the cause is gone.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alert_n_oe <= 1'b0;
    end else if (ctrl[CTRL_COMPARATOR]) begin
      alert_n_oe <= |al_bus.cond;
    end else begin
      alert_n_oe <= |al_bus.latched;
    end
  end

  assign alert_n_out = 1'b0;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_LOCAL_HIGH] = al_bus.latched[COND_LOCAL_HIGH];
    status_byte[STAT_REMOTE_HIGH] = al_bus.latched[COND_REMOTE_HIGH];
    status_byte[STAT_REMOTE_LOW] = al_bus.latched[COND_REMOTE_LOW];
    case (reg_addr)
      ADDR_LOCAL_TEMP: next_rdata = local_temp;
      ADDR_REMOTE_HI: next_rdata = remote_result[10:3];
      ADDR_REMOTE_LO:
        next_rdata = frac_byte(lo_frozen ? lo_shadow : remote_result[2:0]);
      ADDR_STATUS: next_rdata = status_byte;
      ADDR_LOCAL_HIGH: next_rdata = local_high;
      ADDR_RHIGH_HI: next_rdata = rhigh_hi;
      ADDR_RHIGH_LO: next_rdata = rhigh_lo;
      ADDR_RLOW_HI: next_rdata = rlow_hi;
      ADDR_RLOW_LO: next_rdata = rlow_lo;
      ADDR_OFS_HI: next_rdata = ofs_hi;
      ADDR_OFS_LO: next_rdata = ofs_lo;
      ADDR_CRIT: next_rdata = critical_limit;
      ADDR_HYST: next_rdata = critical_hyst;
      ADDR_FILTER: next_rdata = {5'h00, ctrl};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data is held until the next read strobe.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  local_reading_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    sample_valid |=> local_temp == $past(local_adc))
    else $error("Local reading did not take the converter value.");

  remote_lo_zero_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_rd && reg_addr == ADDR_REMOTE_LO) |=> reg_rdata[4:0] == 5'h00)
    else $error("Remote low byte bits 4 to 0 not zero.");

  low_byte_frozen_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_rd && reg_addr == ADDR_REMOTE_LO && lo_frozen)
    |=> (reg_rdata[7:5] == $past(lo_shadow) && !lo_frozen))
    else $error("Low byte not coherent with the high byte read.");

  offset_sum_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    filt_valid |=> remote_result == 11'($past(filt_data) + $past(fmt11(ofs_hi, ofs_lo))))
    else $error("Remote result is not filtered value plus offset.");

  crit_reset_a: assert property (
    @(posedge sys_clk)
    $rose(rstn) |-> (critical_limit == RST_CRIT && local_high == RST_LOCAL_HIGH))
    else $error("Limits not at their reset values.");

  crit_frozen_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (crit_used && reg_wr && reg_addr == ADDR_CRIT) |=> $stable(critical_limit))
    else $error("Critical limit changed after its single write.");

  crit_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (critical_temp_flag && !($signed(remote_int) < $signed(crit_release))) |=> critical_temp_flag)
    else $error("Critical flag released above the hysteresis point.");

  comparator_alert_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ctrl[CTRL_COMPARATOR] && al_bus.cond == 3'h0) ##1 ctrl[CTRL_COMPARATOR] |-> !alert_n_oe)
    else $error("Comparator alert stayed on without a condition.");

  local_high_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ($signed(local_temp) > $signed(local_high)) |=> status_byte[STAT_LOCAL_HIGH])
    else $error("Local high alarm not latched.");

  remote_high_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ($signed(remote_result) > $signed(fmt11(rhigh_hi, rhigh_lo)))
    |=> status_byte[STAT_REMOTE_HIGH])
    else $error("Remote high alarm not latched.");

  remote_low_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ($signed(remote_result) < $signed(fmt11(rlow_hi, rlow_lo))) |=> status_byte[STAT_REMOTE_LOW])
    else $error("Remote low alarm not latched.");

endmodule

// *** test/host_model.sv ***
// ----------------------------------------------------------------
// Host side of the register port
// ----------------------------------------------------------------
module host_model (
  input wire logic sys_clk, // System clock.
  output logic [7:0] reg_addr, // Register address.
  output logic reg_wr, // Write strobe.
  output logic [7:0] reg_wdata, // Write data.
  output logic reg_rd, // Read strobe.
  output logic critical_limit_unlock, // Configuration unlock bit.
  input wire logic [7:0] reg_rdata // Read data.
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus starts idle; strobes stay low until a task raises them.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    critical_limit_unlock = 1'b0;
  end

  // Lines are inverted after release so that stale values are never mistaken for data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read data is taken one and a half cycles after the strobe was sampled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // The high byte is always fetched first so the pair stays coherent.
  task automatic rd_remote(output logic [7:0] hi, output logic [7:0] lo);
    rd(8'h01, hi);
    rd(8'h10, lo);
  endtask

  // Unused control bits are forced to zero by the host.
  task automatic set_ctrl(input logic [7:0] d);
    wr(8'hbf, {5'h00, d[2:0]});
  endtask

  // The unlock bit is raised only around the limit write.
  task automatic unlock_write(input logic [7:0] d);
    @(negedge sys_clk);
    critical_limit_unlock = 1'b1;
    wr(8'h19, d);
    critical_limit_unlock = 1'b0;
  endtask
endmodule

// *** test/tb_temp_result_regs.sv ***
module tb_temp_result_regs
  import temp_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rstn;
  logic sample_valid;
  logic [7:0] local_adc;
  logic [10:0] remote_adc;
  logic critical_limit_unlock;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic critical_temp_flag;
  logic alert_n_out;
  logic alert_n_oe;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #20 sys_clk = ~sys_clk;

  temp_result_regs i_temp_result_regs (.sys_clk(sys_clk), .rstn(rstn),
    .sample_valid(sample_valid), .local_adc(local_adc), .remote_adc(remote_adc),
    .critical_limit_unlock(critical_limit_unlock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .critical_temp_flag(critical_temp_flag), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe));

  host_model i_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .critical_limit_unlock(critical_limit_unlock),
    .reg_rdata(reg_rdata));

  // The run needs well under a thousand cycles, so a hang is cut at five thousand.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host_model.rd(a, d);
    check(d, exp);
  endtask

  task automatic remote(input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] h;
    logic [7:0] l;
    i_host_model.rd_remote(h, l);
    check(h, hi);
    check(l, lo);
  endtask

  // The result is settled well before four idle cycles have passed.
  task automatic sample(input logic [7:0] l, input logic [10:0] r);
    @(negedge sys_clk);
    local_adc = l;
    remote_adc = r;
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] addrs [10] = '{ADDR_LOCAL_HIGH, ADDR_RHIGH_HI, ADDR_RHIGH_LO, ADDR_RLOW_HI,
      ADDR_RLOW_LO, ADDR_OFS_HI, ADDR_OFS_LO, ADDR_CRIT, ADDR_HYST, ADDR_FILTER};
    logic [7:0] vals [10] = '{8'h46, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55,
      8'h0a, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rchk(addrs[i], vals[i]);
    end
    rchk(8'h33, 8'h00);
    i_host_model.wr(ADDR_LOCAL_HIGH, 8'h5a);
    rchk(ADDR_LOCAL_HIGH, 8'h5a);
    i_host_model.wr(ADDR_LOCAL_HIGH, 8'h46);
    i_host_model.wr(ADDR_RHIGH_LO, 8'hff);
    rchk(ADDR_RHIGH_LO, 8'he0);
    i_host_model.wr(ADDR_RHIGH_LO, 8'h00);
  endtask

  // Offset of 2.25 degrees on 25.0, then a negative reading without offset.
  task automatic t_readings();
    i_host_model.wr(ADDR_OFS_HI, 8'h02);
    i_host_model.wr(ADDR_OFS_LO, 8'h40);
    sample(8'h19, 11'h0c8);
    rchk(ADDR_LOCAL_TEMP, 8'h19);
    i_host_model.wr(ADDR_LOCAL_TEMP, 8'h77);
    rchk(ADDR_LOCAL_TEMP, 8'h19);
    remote(8'h1b, 8'h40);
    i_host_model.wr(ADDR_OFS_HI, 8'h00);
    i_host_model.wr(ADDR_OFS_LO, 8'h00);
    sample(8'h19, 11'h7f4);
    remote(8'hfe, 8'h80);
  endtask

  // A new sample between the two byte reads must not tear the pair.
  task automatic t_coherent();
    logic [7:0] d;
    i_host_model.rd(ADDR_REMOTE_HI, d);
    check(d, 8'hfe);
    sample(8'h19, 11'h7f2);
    rchk(ADDR_REMOTE_LO, 8'h80);
    rchk(ADDR_REMOTE_LO, 8'h40);
  endtask

  task automatic critical_temp_flag_once();
    i_host_model.wr(ADDR_CRIT, 8'h40);
    rchk(ADDR_CRIT, 8'h55);
    i_host_model.unlock_write(8'h40);
    rchk(ADDR_CRIT, 8'h40);
    i_host_model.unlock_write(8'h30);
    rchk(ADDR_CRIT, 8'h40);
  endtask

  // Limit 64, hysteresis 10: set above 64, hold at 55, clear at 53.
  task automatic critical_temp_flag_flag();
    sample(8'h19, 11'h200);
    check({7'h00, critical_temp_flag}, 8'h00);
    sample(8'h19, 11'h208);
    check({7'h00, critical_temp_flag}, 8'h01);
    sample(8'h19, 11'h1b8);
    check({7'h00, critical_temp_flag}, 8'h01);
    sample(8'h19, 11'h1a8);
    check({7'h00, critical_temp_flag}, 8'h00);
  endtask

  // From 30.0 the accumulator steps toward 32.0 by halves, halves, then quarters.
  task automatic t_filter();
    sample(8'h19, 11'h0f0);
    remote(8'h1e, 8'h00);
    i_host_model.set_ctrl(8'h02);
    sample(8'h19, 11'h100);
    remote(8'h1f, 8'h00);
    i_host_model.set_ctrl(8'h04);
    sample(8'h19, 11'h100);
    remote(8'h1f, 8'h80);
    i_host_model.set_ctrl(8'h06);
    rchk(ADDR_FILTER, 8'h06);
    sample(8'h19, 11'h100);
    remote(8'h1f, 8'ha0);
    i_host_model.set_ctrl(8'h00);
    sample(8'h19, 11'h100);
    remote(8'h20, 8'h00);
  endtask

  task automatic t_status();
    rchk(ADDR_STATUS, 8'h00);
    sample(8'h47, 11'h238);
    check({7'h00, alert_n_oe}, 8'h01);
    sample(8'h19, 11'h100);
    check({7'h00, alert_n_oe}, 8'h01);
    rchk(ADDR_STATUS, 8'h50);
    rchk(ADDR_STATUS, 8'h00);
    check({7'h00, alert_n_oe}, 8'h00);
    sample(8'h19, 11'h7f8);
    rchk(ADDR_STATUS, 8'h08);
    rchk(ADDR_STATUS, 8'h08);
    i_host_model.set_ctrl(8'h01);
    sample(8'h19, 11'h100);
    check({7'h00, alert_n_oe}, 8'h00);
    sample(8'h47, 11'h100);
    check({7'h00, alert_n_oe}, 8'h01);
    check({7'h00, alert_n_out}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Inputs start from a known idle level; the one process that drives them sets them here.
  initial begin
    rstn = 1'b0;
    sample_valid = 1'b0;
    local_adc = 8'h00;
    remote_adc = 11'h000;
    do_reset();
    t_reset_values();
    t_readings();
    t_coherent();
    critical_temp_flag_once();
    critical_temp_flag_flag();
    do_reset();
    t_filter();
    t_status();
    test_done();
  end
endmodule
